// ---- common/irq_consts.svh ----
// constants and notes for the three level interrupt controller
// Notes on behaviour
// R01 - enable bit 7 gates all sources; when set each source except watchdog follows its own enable
// R02 - enable bits 6..0: temp, timer2, serial, timer1, ext1, timer0, ext0
// R03 - priority bits 7..0: metering, temp, t2, serial, t1, ext1, t0, ext0
// R04 - second reg: b6 rtc prio, b4 bus prio, b3..0 meter/rtc/supply/bus en
// R05 - reset: enable and priority zero, second reg a0, watchdog ctrl 10
// R06 - equal level ties resolve in a fixed twelve source polling order
// R07 - supply interrupt alone sits at a top level, preempting everything
// R08 - ext0 and ext1 request flags sit at timer control bits 1 and 3
// R09 - timer 2 vector requested by overflow or external flag
// R10 - metering vector requested by summary flag bit 7 of status low
// R11 - temperature request held internally, not visible to software
// R12 - wake-up from core shutdown leaves an external interrupt pending
// R13 - events during core shutdown leave ext request flags unchanged
// R14 - rtc, temperature and bus requests latch until their routine entered
// R15 - clearing rtc midnight or alarm flags keeps pending rtc request
// R16 - clearing bus status bits keeps pending bus request
// R17 - latched rtc and bus requests wait for enable then get serviced
// R18 - vectoring leaves supply, metering, serial and timer2 flags set
// R19 - ext flag auto-clears on entry only when edge triggered
// R20 - level triggered ext line keeps requesting while pin stays low
// R21 - high preempts low, wins ties; same level never preempts
// R22 - vector address 0x0003 plus eight per source up to 0x005b
// R23 - after return or enable/priority access, one instruction before vector
// R24 - vectoring clears timer0/timer1 overflow and edge ext flags
`ifndef IRQ_CONSTS_SVH
`define IRQ_CONSTS_SVH
`define ADDR_IE 8'ha8
`define ADDR_INTERRUPT_ENABLE_PRIORITY_SECOND 8'ha9
`define ADDR_IP 8'hb8
`define ADDR_WATCHDOG_CONTROL 8'hc0
`define ADDR_TIMER_CONTROL 8'h88
`define RST_IE 8'h00
`define RST_IP 8'h00
`define RST_INTERRUPT_ENABLE_PRIORITY_SECOND 8'ha0
`define RST_WATCHDOG_CONTROL 8'h10
`define INTERRUPT_ENABLE_PRIORITY_SECOND_RSVD 8'ha0
`define BIT_GATE 7
`define BIT_EX0_FLAG 1
`define BIT_EX1_FLAG 3
`define BIT_EX0_EDGE 0
`define BIT_EX1_EDGE 2
`define BIT_TF0 5
`define BIT_TF1 7
`define BIT_WDS 2
`define VEC_BASE 16'h0003
`define VEC_STEP 16'h0008
`define NUM_SRC 12
`endif

// ---- common/irq_pkg.sv ----
// types shared by the interrupt controller
package irq_pkg;
    // source index = vector slot order
    typedef enum logic [3:0] {
        SRC_EXT0 = 4'h0, SRC_T0 = 4'h1, SRC_EXT1 = 4'h2, SRC_T1 = 4'h3,
        SRC_SER = 4'h4, SRC_T2 = 4'h5, SRC_TEMP = 4'h6, SRC_BUS = 4'h7,
        SRC_SUP = 4'h8, SRC_MET = 4'h9, SRC_RTC = 4'ha, SRC_WDT = 4'hb
    } src_t;
    typedef struct packed {
        logic valid;
        logic [3:0] src;
        logic [1:0] level;
        logic [15:0] addr;
    } vec_req_t;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;
endpackage : irq_pkg

// ---- logic/irq_select.sv ----
// fixed polling order selector within one level
`timescale 1ns/10ps
`include "irq_consts.svh"
module irq_select (
    input wire logic [11:0] req,
    output logic hit,
    output logic [3:0] src
);
    // poll order, highest first, as source indices
    localparam logic [47:0] ORDER = {4'h8, 4'ha, 4'h9, 4'hb, 4'h6, 4'h0,
                                     4'h1, 4'h2, 4'h3, 4'h7, 4'h4, 4'h5};
    always_comb begin
        hit = 1'b0;
        src = 4'h0;
        for (int i = 11; i >= 0; i--) begin
            if (!hit && req[ORDER[i*4 +: 4]]) begin // R06
                hit = 1'b1;
                src = ORDER[i*4 +: 4];
            end
        end
    end
endmodule : irq_select

// ---- logic/irq_ctrl.sv ----
// three level interrupt controller with register port
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/10ps
`include "irq_consts.svh"
module irq_ctrl #(
    parameter int NSRC = `NUM_SRC
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic ext_line0_pin,
    input wire logic ext_line1_pin,
    input wire logic core_shutdown_mode,
    input wire logic wake_ext0,
    input wire logic wake_ext1,
    input wire logic timer0_set,
    input wire logic timer1_set,
    input wire logic timer2_overflow_flag,
    input wire logic timer2_external_flag,
    input wire logic serial_rx_flag,
    input wire logic serial_tx_flag,
    input wire logic supply_irq_flag,
    input wire logic metering_summary_flag,
    input wire logic watchdog_set,
    input wire logic rtc_interval_source,
    input wire logic temp_conv_source,
    input wire logic serial_bus_source,
    input wire logic insn_done,
    input wire logic reti_done,
    input wire logic vec_ack,
    output logic vec_valid,
    output logic [3:0] vec_src,
    output logic [15:0] vec_addr,
    output logic [1:0] active_level
);
    ////////////////////////////////////////////////////////////////////
    logic [7:0] ie_reg, ip_reg, interrupt_enable_priority_second_reg, watchdog_control_reg, timer_control_reg;
    logic [7:0] ie_next, ip_next, interrupt_enable_priority_second_next, watchdog_control_next, timer_control_next;
    logic [2:0] rtc_pend_reg, rtc_pend_next;
    logic [2:0] stack_reg, stack_next;
    logic hold_reg, hold_next;
    logic [7:0] rdata_next;
    irq_pkg::vec_req_t vec_reg, vec_next;
    irq_pkg::reg_req_t bus;

    typedef enum logic [2:0] {
        ST_RUN = 3'b001, ST_OFFER = 3'b010, ST_HOLD = 3'b100
    } state_t;
    state_t state_reg, state_next;

    assign bus = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
    wire wr_ie = bus.wr && bus.addr == `ADDR_IE;
    wire wr_ip = bus.wr && bus.addr == `ADDR_IP;
    wire wr_interrupt_enable_priority_second = bus.wr && bus.addr == `ADDR_INTERRUPT_ENABLE_PRIORITY_SECOND;
    wire wr_watchdog_control = bus.wr && bus.addr == `ADDR_WATCHDOG_CONTROL;
    wire wr_timer_control = bus.wr && bus.addr == `ADDR_TIMER_CONTROL;
    wire touch_ie_ip = (bus.wr || bus.rd)
        && (bus.addr == `ADDR_IE || bus.addr == `ADDR_IP
            || bus.addr == `ADDR_INTERRUPT_ENABLE_PRIORITY_SECOND);

    ////////////////////////////////////////////////////////////////////
    // entry into a routine
    wire taken = state_reg == ST_OFFER && vec_ack;
    wire [3:0] tk = vec_reg.src;
    function automatic logic entered(input logic t, input logic [3:0] s,
                                     input logic [3:0] which);
        entered = t && s == which;
    endfunction : entered

    // external flags; frozen while core is shut down
    wire edge0 = timer_control_reg[`BIT_EX0_EDGE];
    wire edge1 = timer_control_reg[`BIT_EX1_EDGE];
    logic pin0_d_reg, pin1_d_reg;
    wire fall0 = pin0_d_reg && !ext_line0_pin;
    wire fall1 = pin1_d_reg && !ext_line1_pin;
    wire set_ex0 = !core_shutdown_mode && (edge0 ? fall0 : !ext_line0_pin);
    wire set_ex1 = !core_shutdown_mode && (edge1 ? fall1 : !ext_line1_pin);
    // wake-up leaves a latched pending request instead of a flag
    logic [1:0] wake_pend_reg, wake_pend_next;

    always_comb begin
        timer_control_next = wr_timer_control ? bus.wdata : timer_control_reg;
        // edge-triggered flags clear on entry; level ones follow pin
        if (entered(taken, tk, 4'h0) && edge0)
            timer_control_next[`BIT_EX0_FLAG] = 1'b0; // R19 R24
        if (entered(taken, tk, 4'h2) && edge1)
            timer_control_next[`BIT_EX1_FLAG] = 1'b0; // R19 R24
        if (!edge0 && !core_shutdown_mode)
            timer_control_next[`BIT_EX0_FLAG] = !ext_line0_pin; // R20
        if (!edge1 && !core_shutdown_mode)
            timer_control_next[`BIT_EX1_FLAG] = !ext_line1_pin; // R20
        if (entered(taken, tk, 4'h1)) timer_control_next[`BIT_TF0] = 1'b0; // R24
        if (entered(taken, tk, 4'h3)) timer_control_next[`BIT_TF1] = 1'b0; // R24
        // set wins over clear
        if (set_ex0) timer_control_next[`BIT_EX0_FLAG] = 1'b1; // R08 R13
        if (set_ex1) timer_control_next[`BIT_EX1_FLAG] = 1'b1; // R08 R13
        if (timer0_set) timer_control_next[`BIT_TF0] = 1'b1;
        if (timer1_set) timer_control_next[`BIT_TF1] = 1'b1;
    end

    always_comb begin
        wake_pend_next = wake_pend_reg;
        if (entered(taken, tk, 4'h0)) wake_pend_next[0] = 1'b0;
        if (entered(taken, tk, 4'h2)) wake_pend_next[1] = 1'b0;
        if (core_shutdown_mode && wake_ext0) wake_pend_next[0] = 1'b1; // R12
        if (core_shutdown_mode && wake_ext1) wake_pend_next[1] = 1'b1; // R12
    end

    // rtc, temp, bus latches: only entry clears them
    always_comb begin
        rtc_pend_next = rtc_pend_reg;
        if (entered(taken, tk, 4'ha)) rtc_pend_next[0] = 1'b0; // R14
        if (entered(taken, tk, 4'h6)) rtc_pend_next[1] = 1'b0; // R14
        if (entered(taken, tk, 4'h7)) rtc_pend_next[2] = 1'b0; // R14
        if (rtc_interval_source) rtc_pend_next[0] = 1'b1; // R15
        if (temp_conv_source) rtc_pend_next[1] = 1'b1; // R11
        if (serial_bus_source) rtc_pend_next[2] = 1'b1; // R16
    end

    ////////////////////////////////////////////////////////////////////
    // watchdog timeout flag is set by hardware, kept in control reg
    always_comb begin
        watchdog_control_next = wr_watchdog_control ? bus.wdata : watchdog_control_reg;
        if (watchdog_set) watchdog_control_next[`BIT_WDS] = 1'b1;
    end
    assign ie_next = wr_ie ? bus.wdata : ie_reg; // R02
    assign ip_next = wr_ip ? bus.wdata : ip_reg; // R03
    assign interrupt_enable_priority_second_next = wr_interrupt_enable_priority_second ? (bus.wdata | `INTERRUPT_ENABLE_PRIORITY_SECOND_RSVD)
                                 : interrupt_enable_priority_second_reg; // R04

    ////////////////////////////////////////////////////////////////////
    // raw requests per source index
    logic [11:0] raw, en, hi;
    assign raw = {watchdog_control_reg[`BIT_WDS], rtc_pend_reg[0],
                  metering_summary_flag, supply_irq_flag, // R10 R18
                  rtc_pend_reg[2], rtc_pend_reg[1],
                  timer2_overflow_flag | timer2_external_flag, // R09
                  serial_rx_flag | serial_tx_flag,
                  timer_control_reg[`BIT_TF1],
                  timer_control_reg[`BIT_EX1_FLAG] | wake_pend_reg[1],
                  timer_control_reg[`BIT_TF0],
                  timer_control_reg[`BIT_EX0_FLAG] | wake_pend_reg[0]};
    // watchdog has no enable here; it rides on the gate alone
    assign en = {1'b1, interrupt_enable_priority_second_reg[2], interrupt_enable_priority_second_reg[3], interrupt_enable_priority_second_reg[1],
                 interrupt_enable_priority_second_reg[0], ie_reg[6:0]}; // R02 R04 R17
    assign hi = {1'b0, interrupt_enable_priority_second_reg[6], ip_reg[7], 1'b0,
                 interrupt_enable_priority_second_reg[4], ip_reg[6:0]}; // R03 R04
    wire gate = ie_reg[`BIT_GATE];
    wire [11:0] live = raw & en & {12{gate}}; // R01
    wire [11:0] sup_req = live & 12'h100; // R07
    wire [11:0] hi_req = live & hi & ~12'h100;
    wire [11:0] lo_req = live & ~hi & ~12'h100;

    logic hit_s, hit_h, hit_l;
    logic [3:0] src_s, src_h, src_l;
    irq_select sel_sup (.req(sup_req), .hit(hit_s), .src(src_s));
    irq_select sel_hi (.req(hi_req), .hit(hit_h), .src(src_h));
    irq_select sel_lo (.req(lo_req), .hit(hit_l), .src(src_l));

    // stack bits: 0 low, 1 high, 2 supply level active
    wire can_s = hit_s && !stack_reg[2]; // R07
    wire can_h = hit_h && stack_reg[2:1] == 2'b00; // R21
    wire can_l = hit_l && stack_reg == 3'b000; // R21
    wire want = can_s || can_h || can_l;
    wire [3:0] pick = can_s ? src_s : (can_h ? src_h : src_l); // R06 R21
    wire [1:0] plev = can_s ? 2'd2 : (can_h ? 2'd1 : 2'd0);

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        state_next = state_reg;
        vec_next = vec_reg;
        stack_next = stack_reg;
        hold_next = hold_reg || reti_done || touch_ie_ip; // R23
        if (reti_done) begin
            stack_next = stack_reg[2] ? {1'b0, stack_reg[1:0]}
                       : (stack_reg[1] ? {2'b00, stack_reg[0]} : 3'b000);
        end
        unique case (state_reg)
            ST_RUN: begin
                if (want && !hold_reg && !reti_done && !touch_ie_ip) begin
                    state_next = ST_OFFER;
                    vec_next.valid = 1'b1;
                    vec_next.src = pick;
                    vec_next.level = plev;
                    vec_next.addr = `VEC_BASE
                        + {9'h000, pick, 3'b000}; // R22
                end
                if (hold_reg) state_next = ST_HOLD;
            end
            ST_OFFER: begin
                if (vec_ack) begin
                    state_next = ST_RUN;
                    vec_next.valid = 1'b0;
                    stack_next[vec_reg.level] = 1'b1;
                end
            end
            ST_HOLD: begin
                // wait for one instruction to finish
                // an access in this same cycle starts a fresh hold
                if (insn_done) begin
                    hold_next = reti_done || touch_ie_ip; // R23
                    state_next = ST_RUN;
                end
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        unique case (bus.addr)
            `ADDR_IE: rdata_next = ie_reg;
            `ADDR_IP: rdata_next = ip_reg;
            `ADDR_INTERRUPT_ENABLE_PRIORITY_SECOND: rdata_next = interrupt_enable_priority_second_reg;
            `ADDR_WATCHDOG_CONTROL: rdata_next = watchdog_control_reg;
            `ADDR_TIMER_CONTROL: rdata_next = timer_control_reg;
            default: rdata_next = 8'h00;
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            ie_reg <= `RST_IE; // R05
            ip_reg <= `RST_IP; // R05
            interrupt_enable_priority_second_reg <= `RST_INTERRUPT_ENABLE_PRIORITY_SECOND; // R05
            watchdog_control_reg <= `RST_WATCHDOG_CONTROL; // R05
            timer_control_reg <= 8'h00;
            rtc_pend_reg <= 3'b000;
            wake_pend_reg <= 2'b00;
            stack_reg <= 3'b000;
            hold_reg <= 1'b0;
            state_reg <= ST_RUN;
            vec_reg <= '0;
            reg_rdata <= 8'h00;
            pin0_d_reg <= 1'b1;
            pin1_d_reg <= 1'b1;
        end else begin
            ie_reg <= ie_next;
            ip_reg <= ip_next;
            interrupt_enable_priority_second_reg <= interrupt_enable_priority_second_next;
            watchdog_control_reg <= watchdog_control_next;
            timer_control_reg <= timer_control_next;
            rtc_pend_reg <= rtc_pend_next;
            wake_pend_reg <= wake_pend_next;
            stack_reg <= stack_next;
            hold_reg <= hold_next;
            state_reg <= state_next;
            vec_reg <= vec_next;
            reg_rdata <= bus.rd ? rdata_next : 8'h00;
            pin0_d_reg <= ext_line0_pin;
            pin1_d_reg <= ext_line1_pin;
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            vec_valid <= 1'b0;
            vec_src <= 4'h0;
            vec_addr <= 16'h0000;
            active_level <= 2'b00;
        end else begin
            vec_valid <= vec_next.valid;
            vec_src <= vec_next.src;
            vec_addr <= vec_next.addr;
            active_level <= {stack_next[2], stack_next[1] | stack_next[0]};
        end
    end
endmodule : irq_ctrl

// ---- verif/irq_ctrl_assertions.sv ----
// port checker for the interrupt controller
`timescale 1ns/10ps
module irq_ctrl_checker #(
    parameter int NSRC = 12
) (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic vec_ack,
    input wire logic vec_valid,
    input wire logic [3:0] vec_src,
    input wire logic [15:0] vec_addr,
    input wire logic [1:0] active_level
);
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    logic gate_reg;
    // shadow of the global gate, rebuilt from writes only
    always_ff @(posedge clock) begin
        if (sys_rst)
            gate_reg <= 1'b0;
        else if (reg_wr && reg_addr == 8'ha8)
            gate_reg <= reg_wdata[7];
    end
    ////////////////////////////////////////////////////////////////////
    a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    a_rsvd_ones: assert property (
        $past(reg_rd) && $past(reg_addr) == 8'ha9 |-> reg_rdata[7] &&
        reg_rdata[5]) else $error("reserved bits not one");
    a_vec_addr: assert property (
        vec_valid |-> vec_addr == 16'h0003 + {9'h000, vec_src, 3'h0})
        else $error("vector address wrong");
    a_src_range: assert property (vec_valid |-> vec_src < NSRC)
        else $error("vector source out of range");
    a_vec_hold: assert property (
        vec_valid && !vec_ack |=> vec_valid && $stable(vec_addr))
        else $error("offer dropped before ack");
    // two samples of the gate, since the offer lags the decision
    a_gate_off: assert property (
        !gate_reg && !$past(gate_reg) |-> !$rose(vec_valid))
        else $error("vector while gate closed");
    a_ack_active: assert property (
        vec_valid && vec_ack |=> active_level != 2'b00)
        else $error("no active level after ack");
    a_supply_top: assert property (
        active_level[1] && $past(active_level[1]) |-> !$rose(vec_valid))
        else $error("supply routine preempted");
    c_supply: cover property (vec_valid && vec_ack && vec_src == 4'h8);
    c_nested: cover property (vec_valid && vec_ack && active_level != 2'h0);
    c_rsvd: cover property (reg_rd && reg_addr == 8'ha9);
endmodule : irq_ctrl_checker
bind irq_ctrl irq_ctrl_checker #(.NSRC(NSRC)) u_irq_ctrl_checker (
    .clock, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .vec_ack, .vec_valid, .vec_src, .vec_addr, .active_level
);

// ---- verif/core_model.sv ----
// core model that takes vectors and retires instructions
`timescale 1ns/10ps
module core_model (
    input wire logic clock,
    input wire logic sys_rst,
    input wire logic slow,
    input wire logic vec_valid,
    output logic vec_ack,
    output logic insn_done
);
    logic [2:0] cnt_reg;
    // slow mode lets an offer stand up to eight cycles
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            cnt_reg <= 3'h0;
            vec_ack <= 1'b0;
        end else begin
            cnt_reg <= cnt_reg + 3'h1;
            vec_ack <= vec_valid && !vec_ack && (!slow || cnt_reg == 3'h7);
        end
    end
    // one instruction retires every fourth cycle
    assign insn_done = !sys_rst && cnt_reg[1:0] == 2'h3;
endmodule : core_model

// ---- verif/tb.sv ----
// self-checking bench for the interrupt controller
`timescale 1ns/10ps
module tb;
    logic clock = 1'b0;
    logic sys_rst = 1'b1;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic ext_line0_pin = 1'b1, ext_line1_pin = 1'b1;
    logic core_shutdown_mode = 1'b0, wake_ext0 = 1'b0, wake_ext1 = 1'b0;
    logic timer0_set = 1'b0, timer1_set = 1'b0, watchdog_set = 1'b0;
    logic timer2_overflow_flag = 1'b0, timer2_external_flag = 1'b0;
    logic serial_rx_flag = 1'b0, serial_tx_flag = 1'b0;
    logic supply_irq_flag = 1'b0, metering_summary_flag = 1'b0;
    logic rtc_interval_source = 1'b0, temp_conv_source = 1'b0;
    logic serial_bus_source = 1'b0, reti_done = 1'b0, slow = 1'b0;
    logic insn_done, vec_ack, vec_valid;
    logic [3:0] vec_src;
    logic [15:0] vec_addr;
    logic [1:0] active_level;
    int errors = 0;
    int samples_checked = 0;
    always #25 clock = ~clock;
    irq_ctrl #(.NSRC(12)) u_irq_ctrl (.*);
    core_model u_core_model (.clock, .sys_rst, .slow, .vec_valid, .vec_ack,
        .insn_done);
    ////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        samples_checked++;
        if (got !== exp) begin
            errors++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1;
        chk({8'h00, reg_rdata}, {8'h00, e});
    endtask : rd
    // bits: wake0, timer0, rtc, temp, serial bus
    task automatic pulse(input logic [4:0] m);
        @(posedge clock);
        {wake_ext0, timer0_set, rtc_interval_source, temp_conv_source,
            serial_bus_source} <= m;
        @(posedge clock);
        {wake_ext0, timer0_set, rtc_interval_source, temp_conv_source,
            serial_bus_source} <= 5'h00;
    endtask : pulse
    task automatic reti();
        @(posedge clock);
        reti_done <= 1'b1;
        @(posedge clock);
        reti_done <= 1'b0;
    endtask : reti
    task automatic quiet();
        logic seen;
        seen = 1'b0;
        repeat (20) begin
            @(posedge clock);
            #1;
            seen = seen | vec_valid;
        end
        chk({15'h0000, seen}, 16'h0000);
    endtask : quiet
    // waits for an offer, checks it, then waits for the core to take it
    task automatic wait_vec(input logic [3:0] e);
        int n;
        n = 0;
        @(posedge clock);
        #1;
        while (vec_valid !== 1'b1 && n < 60) begin
            @(posedge clock);
            #1;
            n++;
        end
        chk(vec_addr, 16'h0003 + {9'h000, e, 3'h0});
        chk({12'h000, vec_src}, {12'h000, e});
        while (vec_valid !== 1'b0 && n < 80) begin
            @(posedge clock);
            #1;
            n++;
        end
        if (n >= 60) begin
            errors++;
            close_out();
        end
    endtask : wait_vec
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : close_out
    ////////////////////////////////////////////////////////////////////
    initial begin
        repeat (16) @(posedge clock);
        sys_rst <= 1'b0;
        rd(8'ha8, 8'h00);
        rd(8'ha9, 8'ha0);
        rd(8'hb8, 8'h00);
        rd(8'hc0, 8'h10);
        rd(8'h10, 8'h00);
        wr(8'hb8, 8'ha5);
        rd(8'hb8, 8'ha5);
        wr(8'ha9, 8'h5f);
        rd(8'ha9, 8'hff);
        wr(8'ha8, 8'h7f);
        rd(8'ha8, 8'h7f);
        $display("registers done");
        // all at low level: pending latches wait for the gate
        wr(8'hb8, 8'h00);
        wr(8'ha9, 8'h05);
        wr(8'ha8, 8'h42);
        pulse(5'h0f);
        quiet();
        wr(8'ha8, 8'hc2);
        wait_vec(4'ha);
        reti();
        wait_vec(4'h6);
        reti();
        wait_vec(4'h1);
        reti();
        wait_vec(4'h7);
        reti();
        $display("polling done");
        slow <= 1'b1;
        wr(8'hb8, 8'h40);
        pulse(5'h04);
        wait_vec(4'ha);
        pulse(5'h01);
        quiet();
        pulse(5'h02);
        wait_vec(4'h6);
        supply_irq_flag <= 1'b1;
        wr(8'ha9, 8'h07);
        wait_vec(4'h8);
        chk({14'h0000, active_level}, 16'h0003);
        reti();
        wait_vec(4'h8);
        @(posedge clock);
        supply_irq_flag <= 1'b0;
        reti();
        reti();
        reti();
        wait_vec(4'h7);
        reti();
        slow <= 1'b0;
        $display("preemption done");
        wr(8'ha8, 8'h01);
        wr(8'h88, 8'h01);
        ext_line0_pin <= 1'b0;
        repeat (3) @(posedge clock);
        rd(8'h88, 8'h03);
        @(posedge clock);
        ext_line0_pin <= 1'b1;
        wr(8'ha8, 8'h81);
        wait_vec(4'h0);
        rd(8'h88, 8'h01);
        reti();
        wr(8'h88, 8'h00);
        ext_line0_pin <= 1'b0;
        wait_vec(4'h0);
        reti();
        wait_vec(4'h0);
        @(posedge clock);
        ext_line0_pin <= 1'b1;
        reti();
        // flags must freeze while the core is shut down
        wr(8'ha8, 8'h01);
        wr(8'h88, 8'h01);
        core_shutdown_mode <= 1'b1;
        ext_line0_pin <= 1'b0;
        pulse(5'h10);
        ext_line0_pin <= 1'b1;
        core_shutdown_mode <= 1'b0;
        rd(8'h88, 8'h01);
        wr(8'ha8, 8'h81);
        wait_vec(4'h0);
        reti();
        $display("external lines done");
        // outside level flags stay set through entry
        wr(8'ha9, 8'h08);
        wr(8'ha8, 8'hb0);
        metering_summary_flag <= 1'b1;
        serial_tx_flag <= 1'b1;
        timer2_external_flag <= 1'b1;
        wait_vec(4'h9);
        @(posedge clock);
        metering_summary_flag <= 1'b0;
        reti();
        wait_vec(4'h4);
        reti();
        wait_vec(4'h4);
        @(posedge clock);
        serial_tx_flag <= 1'b0;
        reti();
        wait_vec(4'h5);
        @(posedge clock);
        timer2_external_flag <= 1'b0;
        reti();
        quiet();
        $display("level flags done");
        close_out();
    end
endmodule : tb
